/* logic/tct_params.svh */
// tct_params.svh: register offsets, field positions, reset values and timing counts
// for the thermal clock throttle; included by the package user files.
`ifndef TCT_PARAMS_SVH
`define TCT_PARAMS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TCT_OFS_MSRCTL 12'h000
`define TCT_OFS_ACPICTL 12'h004
`define TCT_OFS_STATUS 12'h008
`define TCT_OFS_IRQST 12'h00C
`define TCT_OFS_IRQMSK 12'h010
`define TCT_OFS_PERIOD 12'h014
`define TCT_OFS_LPWR 12'h018

// ----------------------------------------
// field positions
// ----------------------------------------
`define TCT_MSR_AUTOEN 0
`define TCT_MSR_IRQASSERT 1
`define TCT_MSR_IRQDEASSERT 2
`define TCT_ACPI_DUTY_LO 1
`define TCT_ACPI_DUTY_HI 3
`define TCT_ACPI_ONDEMAND 4
`define TCT_IRQ_ASSERT 0
`define TCT_IRQ_DEASSERT 1

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define TCT_MSRCTL_RST 3'h0
`define TCT_ACPICTL_RST 5'h00
`define TCT_IRQMSK_RST 2'h0
`define TCT_PERIOD_RST 8'h10
`define TCT_AUTO_DUTY 3'h4
`define TCT_HYST_CYC 8'h40

`endif

/* logic/tct_pkg.sv */
// tct_pkg.sv: types shared by the thermal clock throttle modules.
// assumes tct_params.svh is compiled alongside.
`default_nettype none
package tct_pkg;
    typedef enum logic [1:0] {TCT_IDLE, TCT_AUTO, TCT_DEMAND} tct_mode_t;
endpackage : tct_pkg
`default_nettype wire

/* logic/tct_modulator.sv */
// tct_modulator.sv: gating pattern of the core clock enable.
// assumes one step of the period per clock cycle, period register from the top.
`timescale 1ns/1ps
`default_nettype none
module tct_modulator (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic active,
    input wire logic [2:0] duty,
    input wire logic [7:0] stepLen,
    output logic clkOn
);
    logic [7:0] stepCnt_r;
    logic [2:0] phase_r;

    // ----------------------------------------
    // eight phases of stepLen plus one cycles each
    // ----------------------------------------
    // the step length is fixed in core cycles, so the wall-clock cycle time
    // shortens as the core clock speeds up
    always_ff @(posedge clk) begin
        if (!nrst) begin
            stepCnt_r <= 8'h00;
            phase_r <= 3'h0;
        end else if (ce) begin
            if (!active) begin
                stepCnt_r <= 8'h00;
                phase_r <= 3'h0;
            end else if (stepCnt_r >= stepLen) begin
                stepCnt_r <= 8'h00;
                phase_r <= phase_r + 3'h1;
            end else begin
                stepCnt_r <= stepCnt_r + 8'h01;
            end
        end
    end

    // clocks run during the first duty eighths, stop for the rest
    always_comb begin
        clkOn = !active || (phase_r < duty);
    end
endmodule : tct_modulator
`default_nettype wire

/* logic/thermal_clock_throttle.sv */
// thermal_clock_throttle.sv: on-die thermal throttling control with APB registers.
// assumes a synchronous trip comparator input and a resolved processor-hot pin level.
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "tct_params.svh"
module thermal_clock_throttle (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic overTrip,
    input wire logic lowPowerState,
    input wire logic processorHotIn,
    output logic processorHotOut,
    output logic processorHotOe,
    input wire logic snoopReq,
    output logic snoopAck,
    input wire logic intReq,
    output logic intDeliver,
    output logic coreClkEn,
    output logic throttleActive,
    output logic irq
);
    logic [2:0] msrCtl_r;
    logic [4:0] acpiCtl_r;
    logic [1:0] irqSt_r;
    logic [1:0] irqMsk_r;
    logic [7:0] period_r;
    logic hot_r;
    logic [7:0] hystCnt_r;
    logic hotDrive_r;
    logic pinLow_r;
    logic intPend_r;
    tct_pkg::tct_mode_t mode_r;
    tct_pkg::tct_mode_t mode_nxt;
    logic [2:0] dutySel;
    logic clkOn;
    logic throttleOn;
    logic apbWr;
    logic apbRd;
    logic extHot;
    logic pinLow;
    logic evAssert;
    logic evDeassert;
    logic [31:0] rdMux;
    logic rdErr;

    // exact word match; any other byte offset inside a word is unmapped
    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // ----------------------------------------
    // apb access
    // ----------------------------------------
    // zero wait states: every access completes in its first access cycle
    // writes to read-only words are dropped; unmapped words also flag pslverr
    always_comb begin
        apbWr = psel && penable && pwrite;
        apbRd = psel && penable && !pwrite;
    end

    // status word: pin level seen, own drive, hot latch, mode, throttle active
    always_comb begin
        rdMux = 32'h0000_0000;
        rdErr = 1'b0;
        if (hit(paddr, `TCT_OFS_MSRCTL)) begin
            rdMux = {29'h0, msrCtl_r};
        end else if (hit(paddr, `TCT_OFS_ACPICTL)) begin
            rdMux = {27'h0, acpiCtl_r};
        end else if (hit(paddr, `TCT_OFS_STATUS)) begin
            rdMux = {26'h0, pinLow_r, hotDrive_r, hot_r, mode_r, throttleActive};
        end else if (hit(paddr, `TCT_OFS_IRQST)) begin
            rdMux = {30'h0, irqSt_r};
        end else if (hit(paddr, `TCT_OFS_IRQMSK)) begin
            rdMux = {30'h0, irqMsk_r};
        end else if (hit(paddr, `TCT_OFS_PERIOD)) begin
            rdMux = {24'h0, period_r};
        end else if (hit(paddr, `TCT_OFS_LPWR)) begin
            rdMux = {31'h0, lowPowerState};
        end else begin
            rdErr = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && rdErr;
            prdata <= (psel && !penable && !pwrite) ? rdMux : 32'h0000_0000;
        end
    end

    // registered pready lags one cycle, so the access phase is the cycle it is seen high
    logic accWr;
    logic accRd;
    always_comb begin
        accWr = apbWr && pready && !pslverr;
        accRd = apbRd && pready && !pslverr;
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            msrCtl_r <= `TCT_MSRCTL_RST;
        end else if (ce && accWr && hit(paddr, `TCT_OFS_MSRCTL)) begin
            msrCtl_r <= pwdata[2:0];
        end
    end

    // bit 0 of the acpi word has no storage and always reads zero
    always_ff @(posedge clk) begin
        if (!nrst) begin
            acpiCtl_r <= `TCT_ACPICTL_RST;
        end else if (ce && accWr && hit(paddr, `TCT_OFS_ACPICTL)) begin
            acpiCtl_r <= {pwdata[4:1], 1'b0};
        end
    end

    // the mask only gates the irq output; status bits latch regardless
    always_ff @(posedge clk) begin
        if (!nrst) begin
            irqMsk_r <= `TCT_IRQMSK_RST;
            period_r <= `TCT_PERIOD_RST;
        end else if (ce && accWr) begin
            if (hit(paddr, `TCT_OFS_IRQMSK)) begin
                irqMsk_r <= pwdata[1:0];
            end
            if (hit(paddr, `TCT_OFS_PERIOD)) begin
                period_r <= pwdata[7:0];
            end
        end
    end

    // ----------------------------------------
    // temperature with hysteresis
    // ----------------------------------------
    // trip level is the comparator's own; nothing here can move it
    // any return above trip restarts the cool-down count from zero
    // limitation: the window is a fixed core-cycle count, not a temperature band
    always_ff @(posedge clk) begin
        if (!nrst) begin
            hot_r <= 1'b0;
            hystCnt_r <= 8'h00;
        end else if (ce) begin
            if (overTrip) begin
                hot_r <= 1'b1;
                hystCnt_r <= 8'h00;
            end else if (hot_r) begin
                // stay hot until cool for a full hysteresis window
                if (hystCnt_r >= `TCT_HYST_CYC) begin
                    hot_r <= 1'b0;
                    hystCnt_r <= 8'h00;
                end else begin
                    hystCnt_r <= hystCnt_r + 8'h01;
                end
            end
        end
    end

    // ----------------------------------------
    // processor-hot pin
    // ----------------------------------------
    // in low power a new assertion is held off; one already up stays up
    always_ff @(posedge clk) begin
        if (!nrst) begin
            hotDrive_r <= 1'b0;
        end else if (ce) begin
            if (lowPowerState) begin
                // keep what the pin shows on entry, even if the die cools meanwhile;
                // release waits for the exit, when hot_r decides again
                hotDrive_r <= hotDrive_r;
            end else begin
                hotDrive_r <= hot_r;
            end
        end
    end

    // out is parked high in reset so the pin rests at its pull-up level
    always_ff @(posedge clk) begin
        if (!nrst) begin
            processorHotOut <= 1'b1;
            processorHotOe <= 1'b0;
        end else if (ce) begin
            // open drain: only ever pulls low
            processorHotOut <= 1'b0;
            processorHotOe <= hotDrive_r;
        end
    end

    // pin low while not driven by us means an outside party pulls it
    always_comb begin
        pinLow = !processorHotIn;
        extHot = pinLow && !processorHotOe;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pinLow_r <= 1'b0;
        end else if (ce) begin
            pinLow_r <= pinLow;
        end
    end

    // ----------------------------------------
    // pin edge interrupts
    // ----------------------------------------
    // edges are taken on the resolved pin, so our own drive and an outside
    // pull both count; each edge kind needs its enable in the control word
    always_comb begin
        evAssert = pinLow && !pinLow_r && msrCtl_r[`TCT_MSR_IRQASSERT];
        evDeassert = !pinLow && pinLow_r && msrCtl_r[`TCT_MSR_IRQDEASSERT];
    end

    // a new edge in the clearing read wins over the clear
    always_ff @(posedge clk) begin
        if (!nrst) begin
            irqSt_r <= 2'h0;
        end else if (ce) begin
            irqSt_r <= ((accRd && hit(paddr, `TCT_OFS_IRQST)) ? 2'h0 : irqSt_r)
                | {evDeassert, evAssert};
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= |(irqSt_r & irqMsk_r);
        end
    end

    // ----------------------------------------
    // mode selection
    // ----------------------------------------
    // auto first: it must win over on-demand whenever auto is enabled and the die is hot;
    // an outside pull counts only with auto mode enabled, like the own trip
    always_comb begin
        if (msrCtl_r[`TCT_MSR_AUTOEN] && (hot_r || extHot)) begin
            mode_nxt = tct_pkg::TCT_AUTO;
        end else if (acpiCtl_r[`TCT_ACPI_ONDEMAND]) begin
            mode_nxt = tct_pkg::TCT_DEMAND;
        end else begin
            mode_nxt = tct_pkg::TCT_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            mode_r <= tct_pkg::TCT_IDLE;
        end else if (ce) begin
            mode_r <= mode_nxt;
        end
    end

    // one decode of throttling feeds both the modulator and the status output,
    // so the two can never disagree about whether clocks may be gated
    always_comb begin
        throttleOn = (mode_r != tct_pkg::TCT_IDLE);
    end

    always_comb begin
        case (mode_r)
            tct_pkg::TCT_AUTO: dutySel = `TCT_AUTO_DUTY;
            tct_pkg::TCT_DEMAND: begin
                // code 0 is taken as the smallest step, one eighth on
                dutySel = (acpiCtl_r[3:1] == 3'h0) ? 3'h1 : acpiCtl_r[3:1];
            end
            default: dutySel = 3'h0;
        endcase
    end

    // the modulator restarts at phase 0 each time throttling begins
    tct_modulator u_mod (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .active(throttleOn),
        .duty(dutySel),
        .stepLen(period_r),
        .clkOn(clkOn)
    );

    always_ff @(posedge clk) begin
        if (!nrst) begin
            coreClkEn <= 1'b1;
            throttleActive <= 1'b0;
        end else if (ce) begin
            // registered so the gate cannot glitch; it lags the phase by one cycle
            coreClkEn <= clkOn;
            throttleActive <= throttleOn;
        end
    end

    // ----------------------------------------
    // snoop and interrupt delivery
    // ----------------------------------------
    // snoops are answered regardless of gating; interrupts wait for clocks-on
    // requests that arrive while gated wait in intPend_r; several of them
    // merge into one delivery at the next clocks-on cycle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            snoopAck <= 1'b0;
            intPend_r <= 1'b0;
            intDeliver <= 1'b0;
        end else if (ce) begin
            snoopAck <= snoopReq;
            if (clkOn && (intPend_r || intReq)) begin
                intDeliver <= 1'b1;
                intPend_r <= 1'b0;
            end else begin
                intDeliver <= 1'b0;
                intPend_r <= intPend_r || intReq;
            end
        end
    end
endmodule : thermal_clock_throttle
`default_nettype wire

/* tb/tct_checker.sv */
// tct_checker.sv: concurrent checks on the throttle block's ports.
// assumes one clock domain and tct_params.svh on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "tct_params.svh"
module tct_checker (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic overTrip,
    input wire logic lowPowerState,
    input wire logic processorHotOut,
    input wire logic processorHotOe,
    input wire logic snoopReq,
    input wire logic snoopAck,
    input wire logic coreClkEn,
    input wire logic throttleActive
);
    logic autoEn_r;
    // ----------------------------------------
    // shadow of the auto enable, seen at the bus
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            autoEn_r <= 1'h0;
        end else if (ce && psel && penable && pready && pwrite && paddr == `TCT_OFS_MSRCTL) begin
            autoEn_r <= pwdata[`TCT_MSR_AUTOEN];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    bus_answer_a: assert property (psel && !penable && ce |=> pready)
        else $error("no ready after setup");
    unmapped_err_a: assert property (pready && paddr > `TCT_OFS_LPWR |-> pslverr)
        else $error("unmapped access without error");
    idle_rdata_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    snoop_pass_a: assert property (ce |=> snoopAck == $past(snoopReq))
        else $error("snoop not answered");
    auto_trip_a: assert property ((overTrip && autoEn_r && !lowPowerState && ce)[*4]
        |-> throttleActive)
        else $error("hot with auto mode but idle");
    idle_run_a: assert property ((!throttleActive)[*3] |-> coreClkEn)
        else $error("clocks gated while idle");
    hot_drive_a: assert property ((overTrip && !lowPowerState && ce)[*4]
        |-> processorHotOe)
        else $error("hot pin not driven");
    lowpwr_quiet_a: assert property ((lowPowerState && !processorHotOe)[*4]
        |=> !processorHotOe)
        else $error("hot pin raised in low power");
    drive_low_a: assert property (processorHotOe |-> !processorHotOut)
        else $error("hot pin driven high");
    cover property (throttleActive && !coreClkEn);
    cover property (processorHotOe);
    cover property (pready && pslverr);
endmodule : tct_checker
bind thermal_clock_throttle tct_checker chk (.clk(clk), .nrst(nrst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .overTrip(overTrip), .lowPowerState(lowPowerState),
    .processorHotOut(processorHotOut), .processorHotOe(processorHotOe),
    .snoopReq(snoopReq), .snoopAck(snoopAck), .coreClkEn(coreClkEn),
    .throttleActive(throttleActive));
`default_nettype wire

/* tb/tct_platform.sv */
// tct_platform.sv: platform side of the processor-hot wire.
// assumes a pull-up on the wire and an open-drain device driver.
`timescale 1ns/1ps
`default_nettype none
module tct_platform (
    input wire logic processorHotOut,
    input wire logic processorHotOe,
    input wire logic extHot,
    output logic processorHotIn
);
    // wired-and: either party pulls low, the pull-up wins otherwise
    assign processorHotIn = !((processorHotOe && !processorHotOut) || extHot);
endmodule : tct_platform
`default_nettype wire

/* tb/tb.sv */
// tb.sv: self-checking bench for the thermal clock throttle.
// assumes the design, checker and platform files are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "tct_params.svh"
module tb;
    typedef struct packed {
        logic w;
        logic [11:0] a;
        logic [15:0] d;
        logic [15:0] e;
        logic err;
    } tct_row_t;
    logic clk, nrst, ce, psel, penable, pwrite, pready, pslverr, overTrip, lowPowerState;
    logic hotIn, hotOut, hotOe, snoopReq, snoopAck, intReq, intDeliver, coreClkEn, active;
    logic irq, extHot, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, on;
    int miscompares = 0;
    int samplesChecked = 0;
    int cyc = 0;
    tct_row_t rows [14];
    thermal_clock_throttle uut (.clk(clk), .nrst(nrst), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .overTrip(overTrip), .lowPowerState(lowPowerState),
        .processorHotIn(hotIn), .processorHotOut(hotOut), .processorHotOe(hotOe),
        .snoopReq(snoopReq), .snoopAck(snoopAck), .intReq(intReq), .intDeliver(intDeliver),
        .coreClkEn(coreClkEn), .throttleActive(active), .irq(irq));
    tct_platform plat (.processorHotOut(hotOut), .processorHotOe(hotOe), .extHot(extHot),
        .processorHotIn(hotIn));
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    // ----------------------------------------
    // watchdog and snoop traffic
    // ----------------------------------------
    always @(posedge clk) begin
        cyc <= cyc + 1;
        snoopReq <= cyc[1];
        if (cyc == 20000) begin
            miscompares++;
            final_report();
        end
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samplesChecked++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    // sums clock-on cycles, or delivery pulses when dl is set
    task automatic count(input int n, input logic dl);
        on = 32'h0;
        repeat (n) begin
            @(posedge clk);
            on = on + 32'(dl ? intDeliver : coreClkEn);
        end
    endtask : count
    task automatic final_report();
        if (miscompares == 0 && samplesChecked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    initial begin
        nrst = 1'h0;
        ce = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        overTrip = 1'h0;
        lowPowerState = 1'h0;
        intReq = 1'h0;
        extHot = 1'h0;
        rows = '{'{1'h0, `TCT_OFS_MSRCTL, 16'h0, 16'h0, 1'h0},
            '{1'h0, `TCT_OFS_ACPICTL, 16'h0, 16'h0, 1'h0},
            '{1'h0, `TCT_OFS_STATUS, 16'h0, 16'h0, 1'h0},
            '{1'h0, `TCT_OFS_IRQST, 16'h0, 16'h0, 1'h0},
            '{1'h0, `TCT_OFS_IRQMSK, 16'h0, 16'h0, 1'h0},
            '{1'h0, `TCT_OFS_PERIOD, 16'h0, 16'h10, 1'h0},
            '{1'h0, `TCT_OFS_LPWR, 16'h0, 16'h0, 1'h0},
            '{1'h1, `TCT_OFS_MSRCTL, 16'h7, 16'h0, 1'h0},
            '{1'h0, `TCT_OFS_MSRCTL, 16'h0, 16'h7, 1'h0},
            '{1'h1, `TCT_OFS_ACPICTL, 16'hF, 16'h0, 1'h0},
            '{1'h0, `TCT_OFS_ACPICTL, 16'h0, 16'hE, 1'h0},
            '{1'h1, `TCT_OFS_PERIOD, 16'h1AB, 16'h0, 1'h0},
            '{1'h0, `TCT_OFS_PERIOD, 16'h0, 16'hAB, 1'h0},
            '{1'h0, 12'h01C, 16'h0, 16'h0, 1'h1}};
        repeat (4) @(posedge clk);
        chk("hot out in reset", 32'(hotOut), 32'h1);
        chk("clocks in reset", 32'(coreClkEn), 32'h1);
        nrst <= 1'h1;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, 32'(rows[i].d));
            chk("slave error", 32'(er), 32'(rows[i].err));
            if (!rows[i].w) chk("read data", rd, 32'(rows[i].e));
        end
        apb(1'h1, `TCT_OFS_MSRCTL, 32'h0);
        apb(1'h1, `TCT_OFS_PERIOD, 32'h0);
        for (int k = 0; k < 8; k++) begin
            apb(1'h1, `TCT_OFS_ACPICTL, 32'h10 | 32'(k << 1));
            repeat (8) @(posedge clk);
            chk("demand active", 32'(active), 32'h1);
            count(64, 1'h0);
            chk("demand duty", on, (k == 0) ? 32'h8 : 32'(8 * k));
        end
        apb(1'h1, `TCT_OFS_PERIOD, 32'h1);
        repeat (20) @(posedge clk);
        count(64, 1'h0);
        chk("longer step", on, 32'h38);
        apb(1'h1, `TCT_OFS_PERIOD, 32'h0);
        apb(1'h1, `TCT_OFS_ACPICTL, 32'h0);
        repeat (4) @(posedge clk);
        chk("demand off", 32'(active), 32'h0);
        count(16, 1'h0);
        chk("clocks run", on, 32'h10);
        apb(1'h1, `TCT_OFS_IRQMSK, 32'h3);
        apb(1'h1, `TCT_OFS_MSRCTL, 32'h7);
        apb(1'h1, `TCT_OFS_ACPICTL, 32'h12);
        overTrip <= 1'h1;
        repeat (10) @(posedge clk);
        count(64, 1'h0);
        chk("auto duty", on, 32'h20);
        chk("irq raised", 32'(irq), 32'h1);
        apb(1'h0, `TCT_OFS_STATUS, 32'h0);
        chk("status", rd, 32'h3B);
        apb(1'h0, `TCT_OFS_IRQST, 32'h0);
        chk("irq status", rd, 32'h1);
        repeat (3) @(posedge clk);
        chk("irq cleared", 32'(irq), 32'h0);
        intReq <= 1'h1;
        @(posedge clk);
        intReq <= 1'h0;
        count(20, 1'h1);
        chk("interrupt served", on, 32'h1);
        apb(1'h1, `TCT_OFS_ACPICTL, 32'h0);
        overTrip <= 1'h0;
        repeat (10) @(posedge clk);
        chk("hysteresis", 32'(active), 32'h1);
        repeat (80) @(posedge clk);
        chk("cooled", 32'(active), 32'h0);
        apb(1'h0, `TCT_OFS_IRQST, 32'h0);
        chk("release edge", rd, 32'h2);
        extHot <= 1'h1;
        repeat (6) @(posedge clk);
        chk("external hot", 32'(active), 32'h1);
        extHot <= 1'h0;
        repeat (100) @(posedge clk);
        lowPowerState <= 1'h1;
        overTrip <= 1'h1;
        repeat (10) @(posedge clk);
        chk("quiet in low power", 32'(hotOe), 32'h0);
        apb(1'h0, `TCT_OFS_LPWR, 32'h0);
        chk("low power flag", rd, 32'h1);
        lowPowerState <= 1'h0;
        repeat (6) @(posedge clk);
        chk("hot asserted", 32'(hotOe), 32'h1);
        lowPowerState <= 1'h1;
        repeat (6) @(posedge clk);
        chk("hot held", 32'(hotOe), 32'h1);
        overTrip <= 1'h0;
        repeat (80) @(posedge clk);
        chk("held while cooling", 32'(hotOe), 32'h1);
        lowPowerState <= 1'h0;
        repeat (4) @(posedge clk);
        chk("released on exit", 32'(hotOe), 32'h0);
        apb(1'h1, `TCT_OFS_ACPICTL, 32'h12);
        repeat (4) @(posedge clk);
        chk("demand before reset", 32'(active), 32'h1);
        nrst <= 1'h0;
        repeat (2) @(posedge clk);
        chk("idle in reset", 32'(active), 32'h0);
        chk("irq in reset", 32'(irq), 32'h0);
        nrst <= 1'h1;
        apb(1'h0, `TCT_OFS_ACPICTL, 32'h0);
        chk("demand after reset", rd, 32'h0);
        final_report();
    end
endmodule : tb
`default_nettype wire
